// >>> common/ssrl_pkg.sv
package ssrl_pkg;
    // ------------------------------------------------------------
    // register widths and power-on values
    // ------------------------------------------------------------
    localparam int SETUP_W = 8;
    localparam int VCO_W = 16;
    localparam int REF_W = 15;
    localparam logic [7:0] SETUP_RST = 8'h00;
    localparam logic [15:0] VCO_RST = 16'h0000;
    localparam logic [14:0] REF_RST = 15'h0000;

    // ------------------------------------------------------------
    // shift path
    // ------------------------------------------------------------
    localparam int SREG_W = 16;
    localparam int CNT_W = 6;
    localparam logic [5:0] CNT_ZERO = 6'h00;
    localparam logic [5:0] CNT_ONE = 6'h01;
    localparam logic [5:0] CNT_SAT = 6'h21;
    localparam int DOUT_TAP = 15;

    // ------------------------------------------------------------
    // transfer lengths
    // ------------------------------------------------------------
    localparam logic [5:0] LEN_RST_A = 6'h04;
    localparam logic [5:0] LEN_RST_B = 6'h05;
    localparam logic [5:0] LEN_SETUP = 6'h08;
    localparam logic [5:0] LEN_REF_A = 6'h0F;
    localparam logic [5:0] LEN_VCO = 6'h10;
    localparam logic [5:0] LEN_REF_B = 6'h18;

    typedef enum logic [2:0] {
        DST_NONE = 3'b000,
        DST_SETUP = 3'b001,
        DST_VCO = 3'b010,
        DST_REF = 3'b100
    } ssrl_dst_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_LOST = 3'b100
    } ssrl_state_t;
endpackage

// >>> common/ssrl_if.sv
`timescale 1ns/100ps
interface ssrl_if;
    logic clear;
    logic shift_en;
    logic bit_rise;
    logic bit_in;
    logic [15:0] sreg;
    logic [5:0] count;

    modport ctl (output clear, output shift_en, output bit_rise, output bit_in,
                 input sreg, input count);
    modport sh (input clear, input shift_en, input bit_rise, input bit_in,
                output sreg, output count);
endinterface

// >>> logic/ssrl_shifter.sv
`timescale 1ns/100ps
module ssrl_shifter (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // control side
    ssrl_if.sh sif
);
    typedef struct packed {
        logic [15:0] sreg;
        logic [5:0] count;
    } ssrl_sh_st_t;

    ssrl_sh_st_t st_q;
    ssrl_sh_st_t st_d;

    // ------------------------------------------------------------
    // shift and count
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (sif.clear) begin
            st_d.count = ssrl_pkg::CNT_ZERO;
        end else if (sif.shift_en && sif.bit_rise) begin
            st_d.sreg = {st_q.sreg[14:0], sif.bit_in}; // RQ1
            if (st_q.count != ssrl_pkg::CNT_SAT) begin
                st_d.count = st_q.count + ssrl_pkg::CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d; // RQ9
        end
    end

    assign sif.sreg = st_q.sreg;
    assign sif.count = st_q.count;
endmodule

// >>> logic/ssrl_top.sv
`timescale 1ns/100ps
// Behaviour
// RQ1: host sends msb first; data bit is taken on rising serial clock.
// RQ2: exactly 8 clocks load the 8-bit setup register.
// RQ3: exactly 16 clocks load the 16-bit feedback divide register.
// RQ4: 15 or 24 clocks load reference divide from last 15 bits.
// RQ5: a 4-clock transfer then a 5-clock transfer resets the device.
// RQ6: registers hold while shifting; update only at strobe release.
// RQ7: destination chosen only by clock count; any order allowed.
// RQ8: serial output changes on each falling serial clock edge.
// RQ9: shift register is static; any clock rate or pause works; code needs each sclk_i level held one clk_sys_i period.
// RQ10: host keeps serial clock steady at power-up or sends reset pattern.
// RQ11: other counts up to 32, and longer ones, update nothing.
// RQ12: strobe rising edge moves shift data into the chosen register.
// RQ13: strobe high inhibits shifting, floats output, keeps port initialised.
// RQ14: host moves strobe only with clock low, else port resyncs later.
module ssrl_top (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // serial port
    input wire logic sclk_i,
    input wire logic sdata_i,
    input wire logic load_strobe_n_i,
    output logic sdata_o,
    output logic sdata_oe_o,
    // programmed registers
    output logic [7:0] setup_reg_o,
    output logic [15:0] vco_divide_reg_o,
    output logic [14:0] ref_divide_reg_o,
    // events and status
    output logic setup_load_o,
    output logic vco_load_o,
    output logic ref_load_o,
    output logic dev_reset_o,
    output logic sync_lost_o
);
    typedef struct packed {
        ssrl_pkg::ssrl_state_t state;
        logic sclk_p;
        logic pend_rst;
        logic dout;
        logic dout_oe;
        logic [7:0] setup;
        logic [15:0] vco;
        logic [14:0] refd;
        logic setup_ld;
        logic vco_ld;
        logic ref_ld;
        logic dev_rst;
        logic lost;
    } ssrl_top_st_t;

    ssrl_top_st_t st_q;
    ssrl_top_st_t st_d;
    ssrl_if sif ();

    // ------------------------------------------------------------
    // destination decode from clock count
    // ------------------------------------------------------------
    function automatic ssrl_pkg::ssrl_dst_t dst_of(input logic [5:0] cnt);
        ssrl_pkg::ssrl_dst_t d;
        d = ssrl_pkg::DST_NONE; // RQ11
        if (cnt == ssrl_pkg::LEN_SETUP) begin
            d = ssrl_pkg::DST_SETUP; // RQ2
        end else if (cnt == ssrl_pkg::LEN_VCO) begin
            d = ssrl_pkg::DST_VCO; // RQ3
        end else if (cnt == ssrl_pkg::LEN_REF_A || cnt == ssrl_pkg::LEN_REF_B) begin
            d = ssrl_pkg::DST_REF; // RQ4
        end
        return d; // RQ7
    endfunction

    // ------------------------------------------------------------
    // shifter
    // ------------------------------------------------------------
    ssrl_shifter u_shifter (
        .clk_sys_i (clk_sys_i),
        .nrst_i (nrst_i),
        .sif (sif.sh)
    );

    logic rise;
    logic fall;
    assign rise = sclk_i & ~st_q.sclk_p;
    assign fall = ~sclk_i & st_q.sclk_p;
    assign sif.clear = (st_q.state != ssrl_pkg::ST_SHIFT); // RQ13
    assign sif.shift_en = (st_q.state == ssrl_pkg::ST_SHIFT) & ~load_strobe_n_i; // RQ13
    assign sif.bit_rise = rise; // RQ1
    assign sif.bit_in = sdata_i;

    // ------------------------------------------------------------
    // port control
    // ------------------------------------------------------------
    always_comb begin
        ssrl_pkg::ssrl_dst_t dst;
        dst = dst_of(sif.count);
        st_d = st_q;
        st_d.sclk_p = sclk_i;
        st_d.setup_ld = 1'b0;
        st_d.vco_ld = 1'b0;
        st_d.ref_ld = 1'b0;
        st_d.dev_rst = 1'b0;
        st_d.dout_oe = ~load_strobe_n_i; // RQ13
        unique case (st_q.state)
            ssrl_pkg::ST_IDLE: begin
                if (!load_strobe_n_i) begin
                    if (sclk_i) begin
                        st_d.state = ssrl_pkg::ST_LOST; // RQ14
                    end else begin
                        st_d.state = ssrl_pkg::ST_SHIFT;
                    end
                end
            end
            ssrl_pkg::ST_SHIFT: begin
                if (fall) begin
                    st_d.dout = sif.sreg[ssrl_pkg::DOUT_TAP]; // RQ8
                end
                if (load_strobe_n_i) begin
                    if (sclk_i) begin
                        st_d.state = ssrl_pkg::ST_LOST; // RQ14
                    end else begin
                        st_d.state = ssrl_pkg::ST_IDLE;
                        st_d.pend_rst = (sif.count == ssrl_pkg::LEN_RST_A);
                        if (st_q.pend_rst && sif.count == ssrl_pkg::LEN_RST_B) begin
                            st_d.setup = ssrl_pkg::SETUP_RST; // RQ5
                            st_d.vco = ssrl_pkg::VCO_RST;
                            st_d.refd = ssrl_pkg::REF_RST;
                            st_d.dev_rst = 1'b1;
                        end
                        unique case (dst)
                            ssrl_pkg::DST_SETUP: begin
                                st_d.setup = sif.sreg[7:0]; // RQ12
                                st_d.setup_ld = 1'b1;
                            end
                            ssrl_pkg::DST_VCO: begin
                                st_d.vco = sif.sreg; // RQ12
                                st_d.vco_ld = 1'b1;
                            end
                            ssrl_pkg::DST_REF: begin
                                st_d.refd = sif.sreg[14:0]; // RQ12
                                st_d.ref_ld = 1'b1;
                            end
                            ssrl_pkg::DST_NONE: begin
                                st_d.pend_rst = st_d.pend_rst; // RQ11
                            end
                        endcase
                    end
                end
            end
            ssrl_pkg::ST_LOST: begin
                if (load_strobe_n_i && !sclk_i) begin
                    st_d.state = ssrl_pkg::ST_IDLE; // RQ14
                end
            end
        endcase
        if (load_strobe_n_i) begin
            st_d.dout = 1'b0;
        end
        st_d.lost = (st_d.state == ssrl_pkg::ST_LOST); // RQ14
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q.state <= ssrl_pkg::ST_IDLE;
            st_q.sclk_p <= 1'b0;
            st_q.pend_rst <= 1'b0;
            st_q.dout <= 1'b0;
            st_q.dout_oe <= 1'b0;
            st_q.setup <= ssrl_pkg::SETUP_RST;
            st_q.vco <= ssrl_pkg::VCO_RST;
            st_q.refd <= ssrl_pkg::REF_RST;
            st_q.setup_ld <= 1'b0;
            st_q.vco_ld <= 1'b0;
            st_q.ref_ld <= 1'b0;
            st_q.dev_rst <= 1'b0;
            st_q.lost <= 1'b0;
        end else begin
            st_q <= st_d; // RQ6
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign sdata_o = st_q.dout;
    assign sdata_oe_o = st_q.dout_oe;
    assign setup_reg_o = st_q.setup;
    assign vco_divide_reg_o = st_q.vco;
    assign ref_divide_reg_o = st_q.refd;
    assign setup_load_o = st_q.setup_ld;
    assign vco_load_o = st_q.vco_ld;
    assign ref_load_o = st_q.ref_ld;
    assign dev_reset_o = st_q.dev_rst;
    assign sync_lost_o = st_q.lost;
endmodule

// >>> verif/ssrl_top_properties.sv
`timescale 1ns/100ps
module ssrl_top_props (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // serial port
    input wire logic sclk_i,
    input wire logic sdata_i,
    input wire logic load_strobe_n_i,
    input wire logic sdata_o,
    input wire logic sdata_oe_o,
    // registers and events
    input wire logic [7:0] setup_reg_o,
    input wire logic [15:0] vco_divide_reg_o,
    input wire logic [14:0] ref_divide_reg_o,
    input wire logic setup_load_o,
    input wire logic vco_load_o,
    input wire logic ref_load_o,
    input wire logic dev_reset_o,
    input wire logic sync_lost_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);
    oe_off_a: assert property (load_strobe_n_i |=> !sdata_oe_o)
        else $error("output enabled with strobe high");
    dout_quiet_a: assert property (load_strobe_n_i |=> !sdata_o)
        else $error("output not quiet with strobe high");
    hold_shift_a: assert property (!load_strobe_n_i && !$past(load_strobe_n_i)
        |-> $stable({setup_reg_o, vco_divide_reg_o, ref_divide_reg_o}))
        else $error("register moved while shifting");
    one_dest_a: assert property ($onehot0({setup_load_o, vco_load_o, ref_load_o, dev_reset_o}))
        else $error("more than one destination");
    setup_pulse_a: assert property (setup_load_o |=> !setup_load_o)
        else $error("setup pulse too long");
    setup_chg_a: assert property (!$stable(setup_reg_o) |-> setup_load_o || dev_reset_o)
        else $error("setup changed without load");
    vco_chg_a: assert property (!$stable(vco_divide_reg_o) |-> vco_load_o || dev_reset_o)
        else $error("vco divide changed without load");
    ref_chg_a: assert property (!$stable(ref_divide_reg_o) |-> ref_load_o || dev_reset_o)
        else $error("ref divide changed without load");
    reset_clr_a: assert property (dev_reset_o |-> setup_reg_o == 8'h00
        && vco_divide_reg_o == 16'h0000 && ref_divide_reg_o == 15'h0000)
        else $error("registers not cleared by reset pattern");
    dout_fall_a: assert property ($changed(sdata_o) && sdata_oe_o && $past(sdata_oe_o)
        |-> !$past(sclk_i) && $past(sclk_i, 2))
        else $error("output changed away from falling clock");
endmodule
bind ssrl_top ssrl_top_props i_props (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .sclk_i(sclk_i), .sdata_i(sdata_i), .load_strobe_n_i(load_strobe_n_i),
    .sdata_o(sdata_o), .sdata_oe_o(sdata_oe_o), .setup_reg_o(setup_reg_o),
    .vco_divide_reg_o(vco_divide_reg_o), .ref_divide_reg_o(ref_divide_reg_o),
    .setup_load_o(setup_load_o), .vco_load_o(vco_load_o), .ref_load_o(ref_load_o),
    .dev_reset_o(dev_reset_o), .sync_lost_o(sync_lost_o));

// >>> verif/ssrl_host_model.sv
`timescale 1ns/100ps
module ssrl_host_model (
    // clock
    input wire logic clk_i,
    // serial port
    output logic sclk_o,
    output logic sdata_o,
    output logic load_strobe_n_o
);
    initial begin
        sclk_o = 1'b0;
        sdata_o = 1'b0;
        load_strobe_n_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic xfer(input logic [31:0] v, input int n, input bit bad);
        load_strobe_n_o = 1'b0;
        tick(2);
        for (int i = n - 1; i >= 0; i--) begin
            sdata_o = v[i];
            tick(1);
            sclk_o = 1'b1;
            tick(2);
            sclk_o = 1'b0;
            tick(2);
        end
        if (bad) begin
            sclk_o = 1'b1;
            tick(2);
        end
        load_strobe_n_o = 1'b1;
        tick(2);
        sclk_o = 1'b0;
        sdata_o = ~sdata_o;
        tick(3);
    endtask
endmodule

// >>> verif/synth_serial_register_loader_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module synth_serial_register_loader_tb;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic sclk, sdin, strb_n, dout, dout_oe, setup_ld, vco_ld, ref_ld, dev_rst, lost;
    logic [7:0] setup_v;
    logic [15:0] vco_v;
    logic [14:0] ref_v;
    logic [4:0] seen = 5'h00;
    logic [15:0] rd_bits = 16'h0000;
    logic oe_cap = 1'b0;
    int n_fail = 0;
    int check_count = 0;
    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    ssrl_top i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sclk_i(sclk), .sdata_i(sdin),
        .load_strobe_n_i(strb_n), .sdata_o(dout), .sdata_oe_o(dout_oe),
        .setup_reg_o(setup_v), .vco_divide_reg_o(vco_v), .ref_divide_reg_o(ref_v),
        .setup_load_o(setup_ld), .vco_load_o(vco_ld), .ref_load_o(ref_ld),
        .dev_reset_o(dev_rst), .sync_lost_o(lost));
    ssrl_host_model i_host (.clk_i(clk_sys_i), .sclk_o(sclk), .sdata_o(sdin),
        .load_strobe_n_o(strb_n));
    always @(posedge clk_sys_i) begin
        seen <= seen | {lost, dev_rst, ref_ld, vco_ld, setup_ld};
    end
    always @(posedge sclk) begin
        rd_bits <= {rd_bits[14:0], dout};
        oe_cap <= dout_oe;
    end
    task automatic send(input logic [31:0] v, input int n, input bit bad);
        seen = 5'h00;
        rd_bits = 16'h0000;
        i_host.xfer(v, n, bad);
    endtask
    task automatic t_setup();
        send(32'h000000C6, 8, 1'b0);
        `CHK("setup", 8'hC6, setup_v)
        `CHK("setup events", 5'h01, seen)
        $display("done setup");
    endtask
    task automatic t_vco();
        send(32'h0000C3E1, 16, 1'b0);
        `CHK("vco", 16'hC3E1, vco_v)
        `CHK("setup kept", 8'hC6, setup_v)
        `CHK("vco events", 5'h02, seen)
        $display("done vco");
    endtask
    task automatic t_ref();
        send(32'h00002BCD, 15, 1'b0);
        `CHK("ref15", 15'h2BCD, ref_v)
        `CHK("readback", 16'h21F0, rd_bits)
        `CHK("out enable", 1'b1, oe_cap)
        `CHK("out off", 1'b0, dout_oe)
        `CHK("out quiet", 1'b0, dout)
        send(32'h00FF9234, 24, 1'b0);
        `CHK("ref24", 15'h1234, ref_v)
        `CHK("ref events", 5'h04, seen)
        `CHK("vco kept", 16'hC3E1, vco_v)
        $display("done ref");
    endtask
    task automatic t_other();
        int lens[3] = '{9, 17, 32};
        foreach (lens[i]) begin
            send(32'hFFFFFFFF, lens[i], 1'b0);
            `CHK("other events", 5'h00, seen)
            `CHK("other regs", {8'hC6, 16'hC3E1, 15'h1234}, {setup_v, vco_v, ref_v})
        end
        $display("done other");
    endtask
    task automatic t_lost();
        send(32'h0000005A, 8, 1'b1);
        `CHK("lost events", 5'h10, seen)
        `CHK("setup after lost", 8'hC6, setup_v)
        send(32'h0000003C, 8, 1'b0);
        `CHK("setup resync", 8'h3C, setup_v)
        $display("done lost");
    endtask
    task automatic t_reset();
        send(32'h0000000F, 4, 1'b0);
        `CHK("four alone", 5'h00, seen)
        send(32'h0000001F, 5, 1'b0);
        `CHK("reset events", 5'h08, seen)
        `CHK("reset regs", 39'h0, {setup_v, vco_v, ref_v})
        $display("done reset");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (5) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        @(negedge clk_sys_i);
        t_setup();
        t_vco();
        t_ref();
        t_other();
        t_lost();
        t_reset();
        wrap_up();
    end
endmodule
